//--- design/pib_pkg.sv
package pib_pkg;

  // ****************************************************************
  // register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [11:0] PIB_ADDR_FLAGS1   = 12'h000;
  localparam logic [11:0] PIB_ADDR_FLAGS2   = 12'h004;
  localparam logic [11:0] PIB_ADDR_FLAGS3   = 12'h008;
  localparam logic [11:0] PIB_ADDR_ENABLES1 = 12'h00c;
  localparam logic [11:0] PIB_ADDR_ENABLES2 = 12'h010;
  localparam logic [11:0] PIB_ADDR_ENABLES3 = 12'h014;
  localparam logic [11:0] PIB_ADDR_CONTROL  = 12'h018;
  localparam logic [11:0] PIB_ADDR_STATUS   = 12'h01c;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // register 1
  localparam int PIB_B1_PARALLEL = 7;
  localparam int PIB_B1_CONVERT  = 6;
  localparam int PIB_B1_RX_FULL  = 5;
  localparam int PIB_B1_TX_EMPTY = 4;
  localparam int PIB_B1_SYNC     = 3;
  localparam int PIB_B1_CAPCMP1  = 2;
  localparam int PIB_B1_TIMER2     = 1;
  localparam int PIB_B1_TIMER1     = 0;
  // register 2
  localparam int PIB_B2_COMPAR   = 6;
  localparam int PIB_B2_EEPROM   = 4;
  localparam int PIB_B2_BUSCOL   = 3;
  localparam int PIB_B2_LOWV     = 2;
  localparam int PIB_B2_TIMER3     = 1;
  localparam int PIB_B2_ENHCC    = 0;
  // control register
  localparam int PIB_C_GLOBAL    = 0;
  localparam int PIB_C_PERIPH    = 1;
  localparam int PIB_C_PRIORITY  = 2;

  // ****************************************************************
  // implemented-bit masks and reset values
  // ****************************************************************
  localparam logic [7:0] PIB_MASK1_FULL  = 8'hff;
  localparam logic [7:0] PIB_MASK1_SMALL = 8'h7f;
  localparam logic [7:0] PIB_MASK2_FULL  = 8'h5f;
  localparam logic [7:0] PIB_MASK2_SMALL = 8'h1e;
  localparam logic [7:0] PIB_RST_FLAGS   = 8'h00;
  localparam logic [7:0] PIB_RST_EN12    = 8'h00;
  localparam logic [7:0] PIB_RST_EN3     = 8'hff;
  localparam logic [2:0] PIB_RST_CTRL    = 3'h0;

endpackage : pib_pkg

//--- design/pib_regs_if.sv
`timescale 1ns/1ps
`default_nettype none

// flags, enables and gate controls passed from bank to request combiner
interface pib_regs_if;
  logic [7:0] flags1;
  logic [7:0] flags2;
  logic [7:0] flags3;
  logic [7:0] en1;
  logic [7:0] en2;
  logic [7:0] en3;
  logic       periph_gate;
  logic       pending;

  modport bank (output flags1, flags2, flags3, en1, en2, en3, periph_gate,
                input pending);
  modport comb (input flags1, flags2, flags3, en1, en2, en3, periph_gate,
                output pending);
endinterface : pib_regs_if

`default_nettype wire

//--- design/pib_req_comb.sv
`timescale 1ns/1ps
`default_nettype none

module pib_req_comb (
  pib_regs_if.comb r
);
  import pib_pkg::*;

  // ****************************************************************
  // masked request combine
  // ****************************************************************
  logic any_masked;

  // or of flag and enable over every source
  always_comb begin
    any_masked = |(r.flags1 & r.en1) | |(r.flags2 & r.en2) | |(r.flags3 & r.en3);  // [RL21]
    r.pending  = any_masked & r.periph_gate;  // [RL3]
  end

endmodule : pib_req_comb

`default_nettype wire

//--- design/pib_bank.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RL1] flags set on their event regardless of enables or global enable
// [RL2] software should clear a flag before enabling and after servicing
// [RL3] without priority mode, peripheral global enable must also be set
// [RL4] register 1 holds parallel, converter, serial, capcmp1, timer2, timer1 flags
// [RL5] receive-full flag is read-only, follows buffer, cleared by buffer read
// [RL6] transmit-empty flag is read-only, cleared by writing transmit buffer
// [RL7] capcmp1 flag set on capture or compare, cleared only by software
// [RL8] timer flags set by hardware, held until software writes zero
// [RL9] register 2 holds comparator, eeprom, collision, low-voltage, timer3, enh capcmp
// [RL10] bits 7 and 5 of register 2 and enable 2 read zero
// [RL11] enhanced capcmp flag set on capture or compare, software cleared
// [RL12] small package drops parallel, comparator, enhanced capcmp bits
// [RL13] register 3 holds can invalid, wake, error, tx buffers, rx buffers
// [RL14] can error flag is a summary of several error sources
// [RL15] transmit buffer flag set when its buffer finishes sending
// [RL16] receive buffer flag set when its buffer gets a message
// [RL17] enable registers mirror flag positions; one enables the source
// [RL18] flags and enables 1,2 reset zero; enables 3 reset all ones
// [RL19] enable 2 holds comparator, eeprom, collision, low-voltage, timer3, enh capcmp
// [RL20] priority selection only acts while priority mode is enabled
// [RL21] request equals or of flag and enable, every cycle
module pib_bank #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // register 1 events, one-cycle pulses from on-chip logic; the serial rx-full and tx-empty inputs are levels
  input  wire logic        i_parallel_port_rw_evt,
  input  wire logic        i_converter_done_evt,
  input  wire logic        i_serial_rx_full,
  input  wire logic        i_serial_tx_empty,
  input  wire logic        i_sync_serial_evt,
  input  wire logic        i_capcmp1_evt,
  input  wire logic        i_timer2_match_evt,
  input  wire logic        i_timer1_overflow_evt,
  // register 2 events
  input  wire logic        i_comparator_change_evt,
  input  wire logic        i_eeprom_write_done_evt,
  input  wire logic        i_bus_collision_evt,
  input  wire logic        i_low_voltage_evt,
  input  wire logic        i_timer3_overflow_evt,
  input  wire logic        i_enh_capcmp_evt,
  // register 3 events from the can controller
  input  wire logic        i_can_invalid_msg_evt,
  input  wire logic        i_can_wake_evt,
  input  wire logic [3:0]  i_can_error_srcs,
  input  wire logic [2:0]  i_can_txbuf_done_evt,
  input  wire logic [1:0]  i_can_rxbuf_full_evt,
  // to the core
  output logic             o_periph_irq,
  output logic             o_global_irq_enable,
  output logic             o_priority_mode_enable
);
  import pib_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  flags1;
    logic [7:0]  flags2;
    logic [7:0]  flags3;
    logic [7:0]  en1;
    logic [7:0]  en2;
    logic [7:0]  en3;
    logic [2:0]  ctrl;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } pib_state_t;

  pib_state_t st_r;
  pib_state_t st_nxt;

  pib_regs_if rif ();

  localparam logic [7:0] MASK1 = LARGE_PACKAGE ? PIB_MASK1_FULL : PIB_MASK1_SMALL;
  localparam logic [7:0] MASK2 = LARGE_PACKAGE ? PIB_MASK2_FULL : PIB_MASK2_SMALL;

  // one read-modify-write rule for software-cleared flags:
  // hardware set wins over a software clear in the same cycle
  function automatic logic [7:0] flag_update(input logic [7:0] cur,
                                              input logic [7:0] set,
                                              input logic       wr,
                                              input logic [7:0] wdata,
                                              input logic [7:0] mask);
    logic [7:0] v;
    v = wr ? wdata : cur;
    flag_update = (v | set) & mask;
  endfunction : flag_update

  // ****************************************************************
  // decode and event vectors
  // ****************************************************************
  logic       acc;
  logic       wr_en;
  logic       addr_ok;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] set3;
  logic [7:0] rd8;

  always_comb begin
    acc     = i_psel & i_penable & ~st_r.pready;
    wr_en   = acc & i_pwrite;
    addr_ok = (i_paddr[11:5] == 7'h00) && (i_paddr[1:0] == 2'h0);
    set1 = 8'h00;
    set1[PIB_B1_PARALLEL] = i_parallel_port_rw_evt;     // [RL1] [RL4]
    set1[PIB_B1_CONVERT]  = i_converter_done_evt;
    set1[PIB_B1_SYNC]     = i_sync_serial_evt;
    set1[PIB_B1_CAPCMP1]  = i_capcmp1_evt;              // [RL7]
    set1[PIB_B1_TIMER2]     = i_timer2_match_evt;         // [RL8]
    set1[PIB_B1_TIMER1]     = i_timer1_overflow_evt;      // [RL8]
    set2 = 8'h00;
    set2[PIB_B2_COMPAR]   = i_comparator_change_evt;    // [RL9]
    set2[PIB_B2_EEPROM]   = i_eeprom_write_done_evt;
    set2[PIB_B2_BUSCOL]   = i_bus_collision_evt;
    set2[PIB_B2_LOWV]     = i_low_voltage_evt;
    set2[PIB_B2_TIMER3]     = i_timer3_overflow_evt;
    set2[PIB_B2_ENHCC]    = i_enh_capcmp_evt;           // [RL11]
    // can error is one summary bit over all its sources
    set3 = {i_can_invalid_msg_evt, i_can_wake_evt, |i_can_error_srcs,  // [RL13] [RL14]
            i_can_txbuf_done_evt, i_can_rxbuf_full_evt};               // [RL15] [RL16]
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    case (i_paddr)
      PIB_ADDR_FLAGS1:   rd8 = st_r.flags1;
      PIB_ADDR_FLAGS2:   rd8 = st_r.flags2;
      PIB_ADDR_FLAGS3:   rd8 = st_r.flags3;
      PIB_ADDR_ENABLES1: rd8 = st_r.en1;
      PIB_ADDR_ENABLES2: rd8 = st_r.en2;
      PIB_ADDR_ENABLES3: rd8 = st_r.en3;
      PIB_ADDR_CONTROL:  rd8 = {5'h00, st_r.ctrl};
      PIB_ADDR_STATUS:   rd8 = {7'h00, st_r.irq};
      default:           rd8 = 8'h00;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    // apb answers in the cycle after the first access cycle
    st_nxt.pready  = acc;
    st_nxt.pslverr = acc & ~addr_ok;
    st_nxt.prdata  = (acc & ~i_pwrite) ? {24'h000000, rd8} : 32'h00000000;

    st_nxt.flags1 = flag_update(st_r.flags1, set1,
                                wr_en && i_paddr == PIB_ADDR_FLAGS1, i_pwdata[7:0],
                                MASK1);  // [RL12]
    // serial buffer flags are status levels, writes never touch them
    st_nxt.flags1[PIB_B1_RX_FULL]  = i_serial_rx_full;   // [RL5]
    st_nxt.flags1[PIB_B1_TX_EMPTY] = i_serial_tx_empty;  // [RL6]
    st_nxt.flags2 = flag_update(st_r.flags2, set2,
                                wr_en && i_paddr == PIB_ADDR_FLAGS2, i_pwdata[7:0],
                                MASK2);  // [RL10] [RL12]
    st_nxt.flags3 = flag_update(st_r.flags3, set3,
                                wr_en && i_paddr == PIB_ADDR_FLAGS3, i_pwdata[7:0],
                                8'hff);
    // enables mirror the flag layout
    if (wr_en && i_paddr == PIB_ADDR_ENABLES1) begin
      st_nxt.en1 = i_pwdata[7:0] & MASK1;  // [RL17]
    end
    if (wr_en && i_paddr == PIB_ADDR_ENABLES2) begin
      st_nxt.en2 = i_pwdata[7:0] & MASK2;  // [RL19] [RL10]
    end
    if (wr_en && i_paddr == PIB_ADDR_ENABLES3) begin
      st_nxt.en3 = i_pwdata[7:0];
    end
    if (wr_en && i_paddr == PIB_ADDR_CONTROL) begin
      st_nxt.ctrl = i_pwdata[2:0];
    end
    st_nxt.irq = rif.pending;  // [RL21]
  end

  // interface feed; in priority mode the one combined request goes to the core
  // priority logic, so the peripheral gate is bypassed there
  assign rif.flags1      = st_r.flags1;
  assign rif.flags2      = st_r.flags2;
  assign rif.flags3      = st_r.flags3;
  assign rif.en1         = st_r.en1;
  assign rif.en2         = st_r.en2;
  assign rif.en3         = st_r.en3;
  assign rif.periph_gate = st_r.ctrl[PIB_C_PRIORITY] | st_r.ctrl[PIB_C_PERIPH];  // [RL3] [RL20]

  pib_req_comb u_comb (
    .r (rif.comb)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r.flags1  <= PIB_RST_FLAGS;  // [RL18]
      st_r.flags2  <= PIB_RST_FLAGS;
      st_r.flags3  <= PIB_RST_FLAGS;
      st_r.en1     <= PIB_RST_EN12;
      st_r.en2     <= PIB_RST_EN12;
      st_r.en3     <= PIB_RST_EN3;    // [RL18]
      st_r.ctrl    <= PIB_RST_CTRL;
      st_r.prdata  <= 32'h00000000;
      st_r.pready  <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.irq     <= 1'b0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_prdata               = st_r.prdata;
  assign o_pready               = st_r.pready;
  assign o_pslverr              = st_r.pslverr;
  assign o_periph_irq           = st_r.irq;
  assign o_global_irq_enable    = st_r.ctrl[PIB_C_GLOBAL];
  assign o_priority_mode_enable = st_r.ctrl[PIB_C_PRIORITY];

endmodule : pib_bank

`default_nettype wire

//--- test/pib_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// port checker of the register bank
// ****
module pib_bank_chk
  import pib_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_serial_rx_full,
  input wire logic        i_serial_tx_empty,
  input wire logic        o_periph_irq,
  input wire logic        o_global_irq_enable,
  input wire logic        o_priority_mode_enable
);
  logic [2:0] ctl_r;
  logic [1:0] lvl;
  logic       ctl_wr;
  logic       rd_ok;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // completed transfers as the master sees them; levels of the serial buffers
  assign ctl_wr = i_psel && i_penable && i_pwrite && o_pready && i_paddr == PIB_ADDR_CONTROL;
  assign rd_ok  = i_psel && i_penable && !i_pwrite && o_pready;
  assign lvl    = {i_serial_rx_full, i_serial_tx_empty};

  // shadow of the gate bits, taken where the write completes
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctl_r <= 3'h0;
    end else if (ctl_wr) begin
      ctl_r <= i_pwdata[2:0];
    end
  end

  rst_clear_a: assert property ($past(i_srst) |-> !o_periph_irq && !o_global_irq_enable)
    else $error("outputs not clear after reset");
  rdy_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  err_with_rdy_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  irq_gate_a: assert property (o_periph_irq |-> ctl_r[1] || ctl_r[2])
    else $error("request passed a closed gate");
  gate_mirror_a: assert property (!ctl_wr |-> o_priority_mode_enable == ctl_r[2]
    && o_global_irq_enable == ctl_r[0])
    else $error("gate outputs differ from control");
  hidden_bits_a: assert property (rd_ok && (i_paddr == PIB_ADDR_FLAGS2
    || i_paddr == PIB_ADDR_ENABLES2) |-> !o_prdata[7] && !o_prdata[5])
    else $error("unimplemented bit reads one");
  serial_copy_a: assert property (rd_ok && i_paddr == PIB_ADDR_FLAGS1
    && $past(lvl) == $past(lvl, 3) && $past(lvl, 2) == $past(lvl, 3)
    |-> o_prdata[5:4] == $past(lvl, 2))
    else $error("serial flags do not follow levels");
  // a request without any bus traffic may only drop through the serial levels
  sticky_irq_a: assert property (o_periph_irq && !i_psel && lvl == 2'b00
    && $past(lvl) == 2'b00 && $past(lvl, 2) == 2'b00 |=> o_periph_irq)
    else $error("request dropped without a write");
endmodule : pib_bank_chk

bind pib_bank pib_bank_chk u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_serial_rx_full(i_serial_rx_full),
  .i_serial_tx_empty(i_serial_tx_empty), .o_periph_irq(o_periph_irq),
  .o_global_irq_enable(o_global_irq_enable), .o_priority_mode_enable(o_priority_mode_enable)
);

`default_nettype wire

//--- test/pib_evt_src.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// on-chip event sources
// ****
module pib_evt_src (
  input  wire logic        i_fire,
  input  wire logic [4:0]  i_sel,
  output logic      [31:0] o_evt
);
  // one source pulses while fired, all others stay quiet
  assign o_evt = i_fire ? (32'h1 << i_sel) : 32'h0;
endmodule : pib_evt_src

`default_nettype wire

//--- test/pib_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// register bank bench
// ****
module pib_bank_tb;
  import pib_pkg::*;

  logic        clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic        rx_full, tx_empty, fire, irq, global_irq_enable, priority_mode_enable, ce;
  logic [4:0]  sel;
  logic [11:0] paddr, fa;
  logic [31:0] pwdata, prdata, rd, evt, prdata_s, rd_s;
  int          num_errors, num_checks;
  // source number in the high byte, flag it must raise in the low byte
  logic [15:0] rows [23] = '{16'h0001, 16'h0102, 16'h0204, 16'h0308, 16'h0640, 16'h0780,
    16'h0801, 16'h0902, 16'h0a04, 16'h0b08, 16'h0c10, 16'h0e40, 16'h1001, 16'h1102,
    16'h1204, 16'h1308, 16'h1410, 16'h1640, 16'h1780, 16'h1820, 16'h1920, 16'h1a20, 16'h1b20};

  pib_evt_src u_src (.i_fire(fire), .i_sel(sel), .o_evt(evt));

  pib_bank uut (
    .i_clk(clk), .i_srst(srst), .i_ce(ce), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_parallel_port_rw_evt(evt[7]),
    .i_converter_done_evt(evt[6]), .i_serial_rx_full(rx_full), .i_serial_tx_empty(tx_empty),
    .i_sync_serial_evt(evt[3]), .i_capcmp1_evt(evt[2]), .i_timer2_match_evt(evt[1]),
    .i_timer1_overflow_evt(evt[0]), .i_comparator_change_evt(evt[14]),
    .i_eeprom_write_done_evt(evt[12]), .i_bus_collision_evt(evt[11]),
    .i_low_voltage_evt(evt[10]), .i_timer3_overflow_evt(evt[9]), .i_enh_capcmp_evt(evt[8]),
    .i_can_invalid_msg_evt(evt[23]), .i_can_wake_evt(evt[22]), .i_can_error_srcs(evt[27:24]),
    .i_can_txbuf_done_evt(evt[20:18]), .i_can_rxbuf_full_evt(evt[17:16]),
    .o_periph_irq(irq), .o_global_irq_enable(global_irq_enable), .o_priority_mode_enable(priority_mode_enable)
  );

  // small package variant on the same bus; only its read data is compared
  pib_bank #(.LARGE_PACKAGE(1'b0)) uut_small (
    .i_clk(clk), .i_srst(srst), .i_ce(ce), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata_s),
    .o_pready(), .o_pslverr(), .i_parallel_port_rw_evt(evt[7]),
    .i_converter_done_evt(evt[6]), .i_serial_rx_full(rx_full), .i_serial_tx_empty(tx_empty),
    .i_sync_serial_evt(evt[3]), .i_capcmp1_evt(evt[2]), .i_timer2_match_evt(evt[1]),
    .i_timer1_overflow_evt(evt[0]), .i_comparator_change_evt(evt[14]),
    .i_eeprom_write_done_evt(evt[12]), .i_bus_collision_evt(evt[11]),
    .i_low_voltage_evt(evt[10]), .i_timer3_overflow_evt(evt[9]), .i_enh_capcmp_evt(evt[8]),
    .i_can_invalid_msg_evt(evt[23]), .i_can_wake_evt(evt[22]), .i_can_error_srcs(evt[27:24]),
    .i_can_txbuf_done_evt(evt[20:18]), .i_can_rxbuf_full_evt(evt[17:16]),
    .o_periph_irq(), .o_global_irq_enable(), .o_priority_mode_enable()
  );

  // free running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one transfer; the request stands until ready, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    rd_s = prdata_s;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    @(posedge clk);
  endtask : apb

  // one-cycle event, then two edges for flag and request to land
  task automatic pulse(input logic [4:0] s);
    sel <= s;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  task automatic rst_chk();
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      check("reset value", (i == 5) ? 32'hff : 32'h0, rd);
    end
    check("reset outputs", {29'h0, irq, global_irq_enable, priority_mode_enable}, 32'h0);
    $display("test reset done");
  endtask : rst_chk

  // main sequence
  initial begin
    {srst, psel, penable, pwrite, rx_full, tx_empty, fire} = 7'h40;
    paddr = 12'h0;
    pwdata = 32'h0;
    sel = 5'h0;
    ce = 1'b1;
    num_errors = 0;
    num_checks = 0;
    @(posedge clk);
    rst_chk();
    // every event-set flag (all but the two serial level flags) is first seen masked, then enabled, then cleared
    apb(1'b1, PIB_ADDR_ENABLES3, 32'h0);
    apb(1'b1, PIB_ADDR_CONTROL, 32'h2);
    foreach (rows[i]) begin
      fa = (rows[i][15:8] > 8'd23) ? 12'h008 : {8'h0, rows[i][12:11], 2'b00};
      pulse(rows[i][12:8]);
      apb(1'b0, fa, 32'h0);
      check("flag", {24'h0, rows[i][7:0]}, rd);
      check("masked irq", {31'h0, irq}, 32'h0);
      apb(1'b1, fa + 12'h00c, {24'h0, rows[i][7:0]});
      check("enabled irq", {31'h0, irq}, 32'h1);
      apb(1'b1, fa, 32'h0);
      check("cleared irq", {31'h0, irq}, 32'h0);
      apb(1'b1, fa + 12'h00c, 32'h0);
    end
    $display("test sources done");
    // unimplemented bits of the second pair, then every gate setting
    apb(1'b1, PIB_ADDR_ENABLES2, 32'hffff_ffff);
    apb(1'b0, PIB_ADDR_ENABLES2, 32'h0);
    check("enables2", 32'h5f, rd);
    check("small enables2", 32'h1e, rd_s);
    apb(1'b1, PIB_ADDR_FLAGS2, 32'hffff_ffff);
    apb(1'b0, PIB_ADDR_FLAGS2, 32'h0);
    check("flags2", 32'h5f, rd);
    check("small flags2", 32'h1e, rd_s);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, PIB_ADDR_CONTROL, 32'(c));
      check("gated irq", {31'h0, irq}, {31'h0, c[1] | c[2]});
      check("gate outputs", {30'h0, priority_mode_enable, global_irq_enable}, {30'h0, c[2], c[0]});
    end
    apb(1'b0, PIB_ADDR_STATUS, 32'h0);
    check("status", 32'h1, rd);
    apb(1'b1, PIB_ADDR_FLAGS2, 32'h0);
    $display("test gating done");
    // serial flags follow their levels and ignore a clearing write
    rx_full <= 1'b1;
    tx_empty <= 1'b1;
    apb(1'b1, PIB_ADDR_FLAGS1, 32'h0);
    apb(1'b0, PIB_ADDR_FLAGS1, 32'h0);
    check("serial set", 32'h30, rd);
    rx_full <= 1'b0;
    tx_empty <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, PIB_ADDR_FLAGS1, 32'h0);
    check("serial clear", 32'h0, rd);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    $display("test serial done");
    // a frozen bank must ignore an event that comes while the enable is low
    ce <= 1'b0;
    pulse(5'h00);
    ce <= 1'b1;
    apb(1'b0, PIB_ADDR_FLAGS1, 32'h0);
    check("frozen flag", 32'h0, rd);
    $display("test freeze done");
    // reset in mid-run brings every register back
    apb(1'b1, PIB_ADDR_ENABLES1, 32'hff);
    apb(1'b0, PIB_ADDR_ENABLES1, 32'h0);
    check("enables1", 32'hff, rd);
    check("small enables1", 32'h7f, rd_s);
    rst_chk();
    wrap_up();
  end
endmodule : pib_bank_tb

`default_nettype wire
